// file: design/occ_pkg.sv
// Package for the oscillator control register block
package occ_pkg;
	localparam logic [11:0] OCC_OSC_CTRL_ADDR = 12'hF86;
	localparam logic [7:0] OCC_OSC_CTRL_RST = 8'hA0;
	localparam int OCC_PREC_EN_BIT = 7;
	localparam int OCC_RSVD_BIT = 6;
	localparam int OCC_WDT_EN_BIT = 5;
	localparam int OCC_PRI_FD_BIT = 4;
	localparam int OCC_WDT_FD_BIT = 3;
	localparam int OCC_SEL_LSB = 0;
	// Monitor window: an oscillator edge must arrive within this time
	localparam int OCC_FAIL_WIN_NS = 1000;
	localparam int OCC_CLK_NS = 5;
	localparam int OCC_FAIL_CYC = OCC_FAIL_WIN_NS / OCC_CLK_NS;
	localparam logic [7:0] OCC_FAIL_CYC_W = 8'(OCC_FAIL_CYC);
	// Source select codes
	typedef enum logic [2:0] {
		OCC_SRC_PREC = 3'h0,
		OCC_SRC_PRIMARY = 3'h1,
		OCC_SRC_WDT = 3'h2
	} occ_src_t;
endpackage

// file: design/occ_osc_mon.sv
// Oscillator activity monitor: flags loss of edges on a slow oscillator
`timescale 1ns/1ps
module occ_osc_mon (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic enable,
	input wire logic osc_in,
	output logic fail
);
	logic [2:0] sync_q;
	logic [7:0] cnt_q;
	logic edge_seen;

	// Three stages; only the agreed later two are looked at
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync_q <= 3'h0;
		end else begin
			sync_q <= {sync_q[1:0], osc_in};
		end
	end

	assign edge_seen = sync_q[1] != sync_q[2];

	// Watch window restarts on every oscillator edge
	always_ff @(posedge clk) begin
		if (sys_rst || !enable) begin
			cnt_q <= 8'h00;
			fail <= 1'b0;
		end else if (edge_seen) begin
			cnt_q <= 8'h00;
		end else if (cnt_q == occ_pkg::OCC_FAIL_CYC_W) begin
			fail <= 1'b1; // Sticky until monitoring is turned off
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
endmodule

// file: design/occ_top.sv
// Oscillator control register with failure monitors and clock select
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module occ_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic primary_osc_in,
	input wire logic watchdog_osc_in,
	output logic precision_osc_run,
	output logic watchdog_osc_run,
	output logic [2:0] clock_source,
	output logic primary_osc_failed,
	output logic watchdog_osc_failed
);
	logic precision_osc_enable_q;
	logic watchdog_osc_enable_q;
	logic primary_osc_fail_detect_enable_q;
	logic watchdog_osc_fail_detect_enable_q;
	logic [2:0] system_clock_source_select_q;
	logic [7:0] ctrl_view;
	logic hit_wr;
	logic hit_rd;
	logic pri_fail;
	logic wdt_fail;
	logic [2:0] src_d;

	// Both strobes decode the same single address, so one helper serves
	function automatic logic addr_hit(logic [11:0] addr);
		return addr == occ_pkg::OCC_OSC_CTRL_ADDR;
	endfunction

	// Unmapped addresses fall through: writes ignored, reads give zero
	assign hit_wr = reg_wr && addr_hit(reg_addr);
	assign hit_rd = reg_rd && addr_hit(reg_addr);

	// Register fields; bit 6 is never stored
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			precision_osc_enable_q <= occ_pkg::OCC_OSC_CTRL_RST[7];
			watchdog_osc_enable_q <= occ_pkg::OCC_OSC_CTRL_RST[5];
			primary_osc_fail_detect_enable_q <= occ_pkg::OCC_OSC_CTRL_RST[4];
			watchdog_osc_fail_detect_enable_q <= occ_pkg::OCC_OSC_CTRL_RST[3];
			system_clock_source_select_q <= occ_pkg::OCC_OSC_CTRL_RST[2:0];
		end else if (hit_wr) begin
			precision_osc_enable_q <= reg_wdata[occ_pkg::OCC_PREC_EN_BIT];
			watchdog_osc_enable_q <= reg_wdata[occ_pkg::OCC_WDT_EN_BIT];
			primary_osc_fail_detect_enable_q <=
				reg_wdata[occ_pkg::OCC_PRI_FD_BIT];
			watchdog_osc_fail_detect_enable_q <=
				reg_wdata[occ_pkg::OCC_WDT_FD_BIT];
			system_clock_source_select_q <=
				reg_wdata[occ_pkg::OCC_SEL_LSB +: 3];
		end
	end

	assign ctrl_view = {precision_osc_enable_q, 1'b0, watchdog_osc_enable_q,
		primary_osc_fail_detect_enable_q,
		watchdog_osc_fail_detect_enable_q,
		system_clock_source_select_q};

	// Read data stands only in the cycle after the strobe; unmapped reads 0
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (hit_rd) begin
			reg_rdata <= ctrl_view;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Primary monitor only runs while its detect bit is set
	occ_osc_mon u_pri_mon (
		.clk(clk),
		.sys_rst(sys_rst),
		.enable(primary_osc_fail_detect_enable_q),
		.osc_in(primary_osc_in),
		.fail(pri_fail)
	);

	// Watchdog monitor is pointless when that oscillator is stopped
	occ_osc_mon u_wdt_mon (
		.clk(clk),
		.sys_rst(sys_rst),
		.enable(watchdog_osc_fail_detect_enable_q && watchdog_osc_enable_q),
		.osc_in(watchdog_osc_in),
		.fail(wdt_fail)
	);

	// Source choice; recovery falls back to the precision oscillator
	always_comb begin
		src_d = system_clock_source_select_q;
		if (src_d == occ_pkg::OCC_SRC_PRIMARY && pri_fail) begin
			src_d = occ_pkg::OCC_SRC_PREC;
		end
	end

	// Outputs registered; recovery also forces the precision oscillator on
	// The extra stage costs one cycle but keeps every pin glitch free
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			precision_osc_run <= occ_pkg::OCC_OSC_CTRL_RST[7];
			watchdog_osc_run <= occ_pkg::OCC_OSC_CTRL_RST[5];
			clock_source <= occ_pkg::OCC_OSC_CTRL_RST[2:0];
			primary_osc_failed <= 1'b0;
			watchdog_osc_failed <= 1'b0;
		end else begin
			precision_osc_run <= precision_osc_enable_q ||
				(pri_fail && system_clock_source_select_q ==
				occ_pkg::OCC_SRC_PRIMARY);
			watchdog_osc_run <= watchdog_osc_enable_q;
			clock_source <= src_d;
			primary_osc_failed <= pri_fail;
			watchdog_osc_failed <= wdt_fail;
		end
	end


	// Reserved bit never leaks onto the read bus
	reserved_zero_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		reg_rdata[6] == 1'b0)
		else $error("reserved bit read nonzero");

	// Read data carries the precision enable held at the strobe
	read_back_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		hit_rd |=> reg_rdata[7] == $past(precision_osc_enable_q))
		else $error("read data mismatch");

	// Read data carries the watchdog enable held at the strobe
	read_wdt_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		hit_rd |=> reg_rdata[5] == $past(watchdog_osc_enable_q))
		else $error("watchdog enable read mismatch");

	// Read data carries the primary detect enable
	read_pri_fd_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		hit_rd |=> reg_rdata[4] == $past(primary_osc_fail_detect_enable_q))
		else $error("primary detect read mismatch");

	// Read data carries the watchdog detect enable
	read_wdt_fd_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		hit_rd |=> reg_rdata[3] == $past(watchdog_osc_fail_detect_enable_q))
		else $error("watchdog detect read mismatch");

	// Read data carries the stored select field, not the recovered one
	read_sel_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		hit_rd |=> reg_rdata[2:0] == $past(system_clock_source_select_q))
		else $error("select field read mismatch");

	// Watchdog oscillator follows the written bit two cycles on
	wdt_run_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		hit_wr |=> ##1 watchdog_osc_run == $past(reg_wdata[5], 2))
		else $error("watchdog run not following write");

	// No primary failure may show while its detection is off
	pri_detect_off_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		!primary_osc_fail_detect_enable_q |-> ##2 !primary_osc_failed)
		else $error("primary failure flagged while off");

	// No watchdog failure may show while its detection is off
	wdt_detect_off_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		!watchdog_osc_fail_detect_enable_q |-> ##2 !watchdog_osc_failed)
		else $error("watchdog failure flagged while off");

	// Codes other than primary pass straight to the source output
	src_follow_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		hit_wr && reg_wdata[2:0] != 3'h1 |=> ##1 clock_source ==
		$past(reg_wdata[2:0], 2))
		else $error("source not updated");

	// Setting bit 7 always starts the precision oscillator
	prec_write_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		hit_wr && reg_wdata[7] |=> ##1 precision_osc_run)
		else $error("precision osc not running");

	// Clearing bit 7 stops it unless primary is selected for recovery
	prec_off_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		hit_wr && !reg_wdata[7] && reg_wdata[2:0] != 3'h1
		|=> ##1 !precision_osc_run)
		else $error("precision osc still running");

	// Read bus idles at zero outside the read slot
	idle_read_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		!hit_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");

	// A failed primary source is swapped for the precision oscillator
	recover_src_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		pri_fail && system_clock_source_select_q == 3'h1
		|=> clock_source == 3'h0)
		else $error("no fallback after primary failure");

	// Recovery must also make sure the fallback oscillator runs
	recover_run_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		pri_fail && system_clock_source_select_q == 3'h1
		|=> precision_osc_run)
		else $error("fallback oscillator not running");

	// Reset brings both oscillators up and selects source zero
	reset_defaults_a: assert property (
		@(posedge clk)
		sys_rst |=> precision_osc_run && watchdog_osc_run &&
		clock_source == 3'h0)
		else $error("outputs not at reset defaults");
endmodule

// file: dv/test_oscillator_control_register.sv
// Self-checking bench for the oscillator control register
`timescale 1ns/1ps
module test_oscillator_control_register;
	logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, rd_d = 0;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
	logic primary_osc_in = 0, watchdog_osc_in = 0, pri_on = 1, wd_on = 1;
	logic precision_osc_run, watchdog_osc_run, clk_ok;
	logic primary_osc_failed, watchdog_osc_failed;
	logic [2:0] clock_source;
	logic [7:0] exp_q[$];
	logic [7:0] outs;
	int failures = 0, n_compared = 0;
	// Outputs packed like the register so one expected byte covers all
	assign outs = {precision_osc_run, 1'b0, watchdog_osc_run,
		primary_osc_failed, watchdog_osc_failed, clock_source};
	occ_top dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .primary_osc_in(primary_osc_in),
		.watchdog_osc_in(watchdog_osc_in),
		.precision_osc_run(precision_osc_run),
		.watchdog_osc_run(watchdog_osc_run), .clock_source(clock_source),
		.primary_osc_failed(primary_osc_failed),
		.watchdog_osc_failed(watchdog_osc_failed));
	always #2.5 clk = ~clk;
	// Slow oscillators; either can be stopped to provoke a failure
	always begin
		repeat (16) @(posedge clk);
		if (pri_on) primary_osc_in <= ~primary_osc_in;
		if (wd_on) watchdog_osc_in <= ~watchdog_osc_in;
	end
	task automatic check(string n, logic [7:0] s, logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task end_of_test;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task wr(logic [11:0] a, logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Expected read data is noted when the strobe goes out
	task rd(logic [11:0] a, logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	// Outputs follow a write two cycles later; look mid-cycle after that
	task settle;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask
	// Read data stands only in the cycle after the strobe
	always @(posedge clk) rd_d <= reg_rd;
	always @(negedge clk)
		if (rd_d) check("rdata", reg_rdata, exp_q.pop_front());
	initial begin
		d = $urandom(61401);
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		rd(12'hF86, 8'hA0);
		@(negedge clk);
		check("outs", outs, 8'hA0);
		wr(12'h123, 8'h00);
		rd(12'h123, 8'h00);
		rd(12'hF86, 8'hA0);
		// Every select code once, other bits random, reserved kept zero
		for (int i = 0; i < 8; i++) begin
			d = (8'($urandom) & 8'hB8) | 8'(i);
			wr(12'hF86, d);
			rd(12'hF86, d & 8'hBF);
			settle;
			check("outs", outs,
				{d[7], 1'b0, d[5], 2'b00, d[2:0]});
		end
		// Both oscillators stall with detection on and primary selected
		wr(12'hF86, 8'h39);
		pri_on = 0;
		wd_on = 0;
		repeat (260) @(posedge clk);
		@(negedge clk);
		check("fail", outs, 8'hB8);
		rd(12'hF86, 8'h39);
		wr(12'hF86, 8'h21);
		settle;
		check("nofail", outs, 8'h21);
		// Reset in mid-run restores the defaults
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(12'hF86, 8'hA0);
		@(negedge clk);
		check("rst", outs, 8'hA0);
		end_of_test;
	end
	initial begin
		#10000;
		failures++;
		end_of_test;
	end
endmodule
